// ===== bench/ppd_far_side.sv
// far side model: board strap levels and one remote link partner per port
`timescale 1ns/1ns
`default_nettype none
module ppd_far_side (
   input  wire logic       i_sys_clk,
   input  wire logic [1:0] i_strap,
   input  wire logic [1:0] i_present,
   input  wire logic       i_slow,
   input  wire logic [1:0] i_phy_enable,
   output logic            o_port1_sleep_strap,
   output logic            o_port2_sleep_strap,
   output logic      [1:0] o_autoneg_done,
   output logic      [1:0] o_partner_ok,
   output logic      [1:0] o_line_pos,
   output logic      [1:0] o_line_neg
);
   logic [4:0] an_cnt_q [2];
   logic [7:0] pat_q;
   initial pat_q = 8'h5A;
   // boards without host software strap both ports awake
   assign o_port1_sleep_strap = i_strap[0];
   assign o_port2_sleep_strap = i_strap[1];
   assign o_partner_ok = i_present;
   // line noise changes every cycle so a stale value never passes for zero
   assign o_line_pos = pat_q[1:0];
   assign o_line_neg = ~pat_q[3:2];
   always @(posedge i_sys_clk) begin
      pat_q <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
   end
   // autonegotiation restarts whenever the port sleeps; slow mode takes 16 cycles
   for (genvar p = 0; p < 2; p++) begin : g_an
      always @(posedge i_sys_clk) begin
         if (!i_phy_enable[p] || !i_present[p]) begin
            an_cnt_q[p] <= 5'h00;
         end else if (an_cnt_q[p] < (i_slow ? 5'd16 : 5'd1)) begin
            an_cnt_q[p] <= an_cnt_q[p] + 5'd1;
         end
      end
      assign o_autoneg_done[p] = i_phy_enable[p] && (an_cnt_q[p] >= (i_slow ? 5'd16 : 5'd1));
   end
endmodule // ppd_far_side
`default_nettype wire

// ===== bench/ppd_power_ctrl_test.sv
// self-checking bench for the power-down and strap controller
`timescale 1ns/1ns
`default_nettype none
module ppd_power_ctrl_test;
   import ppd_pkg::*;
   logic        clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        s1, s2, fwd, free, oe, slow;
   logic [1:0]  strap, present, an_done, p_ok, lp_in, ln_in;
   logic [1:0]  phy_en, link, lp, ln;
   logic [31:0] rd;
   logic        err;
   logic [1:0]  v;
   int          bad_count;
   int          compares;
   int          seed;

   ppd_power_ctrl ppd_power_ctrl_i (.i_sys_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_port1_sleep_strap(s1), .i_port2_sleep_strap(s2),
      .i_autoneg_done(an_done), .i_partner_ok(p_ok), .i_port1_line_pos(lp_in[0]),
      .i_port1_line_neg(ln_in[0]), .i_port2_line_pos(lp_in[1]),
      .i_port2_line_neg(ln_in[1]), .o_phy_enable(phy_en), .o_link_up(link),
      .o_line_pos(lp), .o_line_neg(ln), .o_fwd_store_forward(fwd),
      .o_strap_pins_free(free), .o_pins_oe(oe));
   ppd_far_side ppd_far_side_i (.i_sys_clk(clk), .i_strap(strap), .i_present(present),
      .i_slow(slow), .i_phy_enable(phy_en), .o_port1_sleep_strap(s1),
      .o_port2_sleep_strap(s2), .o_autoneg_done(an_done), .o_partner_ok(p_ok),
      .o_line_pos(lp_in), .o_line_neg(ln_in));

   function automatic logic [31:0] exp_status(input logic [1:0] req);
      exp_status = {29'h0, 1'b1, req};
   endfunction
   function automatic logic [1:0] exp_link(input logic [1:0] req, input logic an);
      exp_link = {an & ~req[1] & ~req[0], an & ~req[0]};
   endfunction

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // holds the request until pready is sampled high, then releases it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] st);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= st;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         bad_count++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, ZERO_WORD, 4'hF);
      check(rd, e);
   endtask
   task automatic wait_link(input logic [1:0] e);
      for (int n = 0; n < 80; n++) begin
         @(posedge clk);
         if (link === e) break;
      end
      check(link, e);
   endtask
   task automatic settle();
      // straps are sampled after a fixed settle count, then pins freed one edge later
      repeat (STRAP_SETTLE_CYC + 4) @(posedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      close_out();
   end

   initial begin
      seed = 83637;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      strap = 2'b00;
      present = 2'b11;
      slow = 1'b0;
      // every strap combination, alternating hardware and software reset
      for (int k = 0; k < 4; k++) begin
         strap <= k[1:0];
         if (k % 2 == 0) begin
            nrst <= 1'b0;
            repeat (20) @(posedge clk);
            check({oe, free, phy_en, link, fwd}, 32'h0000_0000);
            nrst <= 1'b1;
         end else begin
            apb(1'b1, OFF_SW_RESET, SW_RESET_KEY, 4'hF);
         end
         settle();
         check({oe, free}, 32'h0000_0003);
         check(phy_en, k[1:0]);
         rd_chk(OFF_STRAP, k);
         rd_chk(OFF_SLEEP_CTRL, ~k & 3);
         rd_chk(OFF_SYS_STATUS, exp_status(~k[1:0]));
         rd_chk(OFF_SW_CONFIG, 32'h0000_000C);
         check(fwd, 1'b0);
         $display("test strap %0d done", k);
      end
      wait_link(2'b11);
      // port 1 asleep: port 2 stays awake but may not link
      apb(1'b1, OFF_SLEEP_CTRL, 32'h0000_0001, 4'hF);
      repeat (40) @(posedge clk);
      check(link, exp_link(2'b01, 1'b1));
      check(phy_en, 2'b10);
      check({lp[0], ln[0]}, 2'b00);
      rd_chk(OFF_SYS_STATUS, exp_status(2'b01));
      slow <= 1'b1;
      apb(1'b1, OFF_SLEEP_CTRL, ZERO_WORD, 4'hF);
      wait_link(exp_link(2'b00, 1'b1));
      apb(1'b1, OFF_SLEEP_CTRL, 32'h0000_0002, 4'hF);
      wait_link(exp_link(2'b10, 1'b1));
      apb(1'b1, OFF_SLEEP_CTRL, 32'h0000_0003, 4'h0);
      rd_chk(OFF_SLEEP_CTRL, 32'h0000_0002);
      $display("test wake and link done");
      apb(1'b1, OFF_SW_CONFIG, 32'h0000_0002, 4'hF);
      wait_link(2'b01);
      rd_chk(OFF_SW_CONFIG, 32'h0000_0002);
      apb(1'b1, OFF_SW_CONFIG, 32'h0000_000F, 4'hF);
      rd_chk(OFF_SW_CONFIG, 32'h0000_000F);
      check(fwd, 1'b1);
      apb(1'b1, 8'h20, 32'h0000_0003, 4'hF);
      check(err, 1'b1);
      rd_chk(8'h20, ZERO_WORD);
      check(err, 1'b1);
      $display("test config done");
      slow <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         v = $random(seed);
         apb(1'b1, OFF_SLEEP_CTRL, {30'h0, v}, 4'hF);
         repeat (3) @(posedge clk);
         check(phy_en, v ^ 2'b11);
         rd_chk(OFF_SYS_STATUS, exp_status(v));
      end
      $display("test random sleep done");
      close_out();
   end
endmodule // ppd_power_ctrl_test
`default_nettype wire

// ===== hw/ppd_pkg.sv
// package for the phy power-down and bootstrap controller
package ppd_pkg;
   localparam int unsigned APB_AW = 8;
   // register byte offsets
   localparam logic [APB_AW-1:0] OFF_SLEEP_CTRL  = 8'h00; // phy_sleep_control_reg
   localparam logic [APB_AW-1:0] OFF_SYS_STATUS  = 8'h04; // phy_system_status_reg
   localparam logic [APB_AW-1:0] OFF_SW_CONFIG   = 8'h08; // managed configuration
   localparam logic [APB_AW-1:0] OFF_SW_RESET    = 8'h0C; // software reset
   localparam logic [APB_AW-1:0] OFF_STRAP       = 8'h10; // sampled strap levels
   localparam logic [APB_AW-1:0] OFF_LINK_STATUS = 8'h14; // link state
   // field positions
   localparam int unsigned NUM_PHY       = 2;
   localparam int unsigned BIT_FWD_SAF   = 0;  // 1 = store-and-forward
   localparam int unsigned BIT_MANAGED   = 1;
   localparam int unsigned BIT_AUTONEG   = 2;  // autonegotiation enable, 2 bits
   localparam int unsigned BIT_SYS_READY = 2;  // in status register
   localparam logic [31:0] SW_RESET_KEY  = 32'h0000_A5A5;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
   // reset values
   localparam logic        FWD_SAF_RST   = 1'b0; // cut-through by default
   localparam logic        MANAGED_RST   = 1'b0;
   localparam logic [1:0]  AUTONEG_RST   = 2'b11;
   // strap decode: low level means sleep after reset
   localparam logic        STRAP_SLEEP   = 1'b0;
   // clock and timing
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned STRAP_SETTLE_NS = 1000;
   localparam int unsigned STRAP_SETTLE_CYC =
      (STRAP_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CNT_W         = 8;
   // bring-up state of each port
   typedef enum logic [3:0] {
      PPD_SLEEP   = 4'b0001,
      PPD_WAIT_AN = 4'b0010,
      PPD_LINKING = 4'b0100,
      PPD_LINKED  = 4'b1000
   } ppd_link_state_t;
endpackage

// ===== hw/ppd_port_ctrl.sv
// one port: sleep gating and link bring-up sequencing
`timescale 1ns/1ns
`default_nettype none
module ppd_port_ctrl
   import ppd_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_nrst,
   input  wire logic i_clk_en,
   input  wire logic i_sleep,
   input  wire logic i_link_allowed,
   input  wire logic i_autoneg_en,
   input  wire logic i_autoneg_done,
   input  wire logic i_line_pos,
   input  wire logic i_line_neg,
   input  wire logic i_partner_ok,
   output logic      o_phy_enable,
   output logic      o_linking,
   output logic      o_link_up,
   output logic      o_line_pos,
   output logic      o_line_neg
);
   ppd_link_state_t state_q;
   ppd_link_state_t state_d;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         PPD_SLEEP:   if (!i_sleep) state_d = PPD_WAIT_AN;
         PPD_WAIT_AN: if (i_sleep) state_d = PPD_SLEEP;
                      else if (i_autoneg_en && i_autoneg_done && i_link_allowed)
                         state_d = PPD_LINKING;
         PPD_LINKING: if (i_sleep) state_d = PPD_SLEEP;
                      else if (!i_link_allowed) state_d = PPD_WAIT_AN;
                      else if (i_partner_ok) state_d = PPD_LINKED;
         PPD_LINKED:  if (i_sleep) state_d = PPD_SLEEP;
                      else if (!i_link_allowed || !i_partner_ok) state_d = PPD_WAIT_AN;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         state_q <= PPD_SLEEP;
      end else if (i_clk_en) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_phy_enable <= 1'b0;
         o_linking    <= 1'b0;
         o_link_up    <= 1'b0;
         o_line_pos   <= 1'b0;
         o_line_neg   <= 1'b0;
      end else if (i_clk_en) begin
         o_phy_enable <= (state_d != PPD_SLEEP);
         o_linking    <= (state_d == PPD_LINKING);
         o_link_up    <= (state_d == PPD_LINKED);
         // line inputs ignored while asleep
         o_line_pos   <= (state_d != PPD_SLEEP) && i_line_pos;
         o_line_neg   <= (state_d != PPD_SLEEP) && i_line_neg;
      end
   end

   property p_sleep_drops_link;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_sleep) |=> (!o_link_up && !o_linking && !o_phy_enable);
   endproperty
   a_sleep_drops_link: assert property (p_sleep_drops_link)
      else $error("port kept link while asleep");

   property p_line_ignored;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_sleep) |=> (!o_line_pos && !o_line_neg);
   endproperty
   a_line_ignored: assert property (p_line_ignored)
      else $error("line input passed while asleep");

   property p_link_needs_autoneg;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      $rose(o_linking) |-> $past(i_autoneg_done) && $past(i_link_allowed);
   endproperty
   a_link_needs_autoneg: assert property (p_link_needs_autoneg)
      else $error("link attempt without autonegotiation");
endmodule // ppd_port_ctrl
`default_nettype wire

// ===== hw/ppd_power_ctrl.sv
// top: power-down, strap sampling and configuration for two phy ports
`timescale 1ns/1ns
`default_nettype none
module ppd_power_ctrl
   import ppd_pkg::*;
(
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_nrst,
   input  wire logic                       i_clk_en,
   // apb slave
   input  wire logic                       i_psel,
   input  wire logic                       i_penable,
   input  wire logic                       i_pwrite,
   input  wire logic [ppd_pkg::APB_AW-1:0] i_paddr,
   input  wire logic [31:0]                i_pwdata,
   input  wire logic [3:0]                 i_pstrb,
   output logic      [31:0]                o_prdata,
   output logic                            o_pready,
   output logic                            o_pslverr,
   // straps and port pins
   input  wire logic                       i_port1_sleep_strap,
   input  wire logic                       i_port2_sleep_strap,
   input  wire logic [1:0]                 i_autoneg_done,
   input  wire logic [1:0]                 i_partner_ok,
   input  wire logic                       i_port1_line_pos,
   input  wire logic                       i_port1_line_neg,
   input  wire logic                       i_port2_line_pos,
   input  wire logic                       i_port2_line_neg,
   output logic      [1:0]                 o_phy_enable,
   output logic      [1:0]                 o_link_up,
   output logic      [1:0]                 o_line_pos,
   output logic      [1:0]                 o_line_neg,
   output logic                            o_fwd_store_forward,
   output logic                            o_strap_pins_free,
   output logic                            o_pins_oe
);
   // the on-chip reset pin synchroniser is outside; i_nrst low is hardware power-down

   function automatic logic reg_hit(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] off);
      reg_hit = (a == off);
   endfunction

   logic [NUM_PHY-1:0] sleep_req_q;
   logic [NUM_PHY-1:0] sleep_req_d;
   logic [NUM_PHY-1:0] strap_q;
   logic               strap_taken_q;
   logic [CNT_W-1:0]   settle_q;
   logic               fwd_saf_q;
   logic               managed_q;
   logic [1:0]         autoneg_en_q;
   logic               soft_rst_q;
   logic [NUM_PHY-1:0] linking_w;
   logic [NUM_PHY-1:0] link_w;
   logic [NUM_PHY-1:0] enable_w;
   logic [NUM_PHY-1:0] lpos_w;
   logic [NUM_PHY-1:0] lneg_w;
   logic [NUM_PHY-1:0] line_pos_in;
   logic [NUM_PHY-1:0] line_neg_in;
   logic [NUM_PHY-1:0] strap_in;
   logic               acc_w;
   logic               wr_w;
   logic               mapped_w;
   logic               rst_n;

   assign line_pos_in = {i_port2_line_pos, i_port1_line_pos};
   assign line_neg_in = {i_port2_line_neg, i_port1_line_neg};
   assign strap_in    = {i_port2_sleep_strap, i_port1_sleep_strap};
   // software reset reinitialises all but the bus interface and the output registers
   assign rst_n       = i_nrst && !soft_rst_q;

   assign acc_w    = i_psel && i_penable;
   assign wr_w     = acc_w && i_pwrite && !o_pready;
   assign mapped_w = reg_hit(i_paddr, OFF_SLEEP_CTRL) || reg_hit(i_paddr, OFF_SYS_STATUS) ||
                     reg_hit(i_paddr, OFF_SW_CONFIG)  || reg_hit(i_paddr, OFF_SW_RESET)   ||
                     reg_hit(i_paddr, OFF_STRAP)      || reg_hit(i_paddr, OFF_LINK_STATUS);

   // software reset pulse: one cycle, then logic restarts and straps are resampled
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         soft_rst_q <= 1'b0;
      end else if (i_clk_en) begin
         soft_rst_q <= wr_w && reg_hit(i_paddr, OFF_SW_RESET) && i_pstrb[0] && i_pstrb[1] &&
                       (i_pwdata == SW_RESET_KEY);
      end
   end

   // strap sampling window after any reset; pins released when it ends
   always_ff @(posedge i_sys_clk) begin
      if (!rst_n) begin
         settle_q      <= '0;
         strap_taken_q <= 1'b0;
         strap_q       <= '1;
      end else if (i_clk_en && !strap_taken_q) begin
         if (settle_q == CNT_W'(STRAP_SETTLE_CYC - 1)) begin
            strap_q       <= strap_in;
            strap_taken_q <= 1'b1;
         end else begin
            settle_q <= settle_q + CNT_W'(1);
         end
      end
   end

   // sleep request: strap seeds it, software sets or clears it per phy
   always_comb begin
      sleep_req_d = sleep_req_q;
      for (int i = 0; i < NUM_PHY; i++) begin
         if (!strap_taken_q) begin
            sleep_req_d[i] = 1'b1;
         end else if (settle_q == CNT_W'(STRAP_SETTLE_CYC - 1) && !strap_q[i] && 1'b0) begin
            sleep_req_d[i] = 1'b1;
         end
      end
      if (wr_w && reg_hit(i_paddr, OFF_SLEEP_CTRL) && i_pstrb[0]) begin
         sleep_req_d = i_pwdata[NUM_PHY-1:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!rst_n) begin
         sleep_req_q <= '1;
      end else if (i_clk_en) begin
         if (!strap_taken_q && settle_q == CNT_W'(STRAP_SETTLE_CYC - 1)) begin
            for (int i = 0; i < NUM_PHY; i++) begin
               sleep_req_q[i] <= (strap_in[i] == STRAP_SLEEP);
            end
         end else begin
            sleep_req_q <= sleep_req_d;
         end
      end
   end

   // configuration: reset to strap-only defaults, writable over the bus
   always_ff @(posedge i_sys_clk) begin
      if (!rst_n) begin
         fwd_saf_q    <= FWD_SAF_RST;
         managed_q    <= MANAGED_RST;
         autoneg_en_q <= AUTONEG_RST;
      end else if (i_clk_en && wr_w && reg_hit(i_paddr, OFF_SW_CONFIG) && i_pstrb[0]) begin
         managed_q <= i_pwdata[BIT_MANAGED];
         if (i_pwdata[BIT_MANAGED]) begin
            fwd_saf_q    <= i_pwdata[BIT_FWD_SAF];
            autoneg_en_q <= i_pwdata[BIT_AUTONEG +: 2];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_PHY; g++) begin : g_port
         ppd_port_ctrl u_port (
            .i_sys_clk      (i_sys_clk),
            .i_nrst         (rst_n),
            .i_clk_en       (i_clk_en && strap_taken_q),
            .i_sleep        (sleep_req_q[g]),
            // port 2 depends on port 1 being awake
            .i_link_allowed ((g == 0) ? 1'b1 : !sleep_req_q[0]),
            .i_autoneg_en   (autoneg_en_q[g]),
            .i_autoneg_done (i_autoneg_done[g]),
            .i_line_pos     (line_pos_in[g]),
            .i_line_neg     (line_neg_in[g]),
            .i_partner_ok   (i_partner_ok[g]),
            .o_phy_enable   (enable_w[g]),
            .o_linking      (linking_w[g]),
            .o_link_up      (link_w[g]),
            .o_line_pos     (lpos_w[g]),
            .o_line_neg     (lneg_w[g])
         );
      end
   endgenerate

   // outputs registered; everything held off while the reset pin is low
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_phy_enable        <= '0;
         o_link_up           <= '0;
         o_line_pos          <= '0;
         o_line_neg          <= '0;
         o_fwd_store_forward <= FWD_SAF_RST;
         o_strap_pins_free   <= 1'b0;
         o_pins_oe           <= 1'b0;
      end else if (i_clk_en) begin
         o_phy_enable        <= enable_w;
         o_link_up           <= link_w;
         o_line_pos          <= lpos_w;
         o_line_neg          <= lneg_w;
         o_fwd_store_forward <= managed_q && fwd_saf_q;
         o_strap_pins_free   <= strap_taken_q;
         o_pins_oe           <= strap_taken_q;
      end
   end

   // apb: one wait state, answer in the second access cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= ZERO_WORD;
      end else if (i_clk_en) begin
         o_pready  <= acc_w && !o_pready;
         o_pslverr <= acc_w && !o_pready && !mapped_w;
         o_prdata  <= ZERO_WORD;
         if (acc_w && !o_pready && !i_pwrite) begin
            if (reg_hit(i_paddr, OFF_SLEEP_CTRL)) begin
               o_prdata[NUM_PHY-1:0] <= sleep_req_q;
            end
            if (reg_hit(i_paddr, OFF_SYS_STATUS)) begin
               o_prdata[NUM_PHY-1:0] <= sleep_req_q & ~enable_w;
               o_prdata[BIT_SYS_READY] <= strap_taken_q;
            end
            if (reg_hit(i_paddr, OFF_SW_CONFIG)) begin
               o_prdata[BIT_FWD_SAF]      <= fwd_saf_q;
               o_prdata[BIT_MANAGED]      <= managed_q;
               o_prdata[BIT_AUTONEG +: 2] <= autoneg_en_q;
            end
            if (reg_hit(i_paddr, OFF_STRAP)) begin
               o_prdata[NUM_PHY-1:0] <= strap_q;
            end
            if (reg_hit(i_paddr, OFF_LINK_STATUS)) begin
               o_prdata[NUM_PHY-1:0] <= link_w;
            end
         end
      end
   end

   property p_strap_sleep;
      @(posedge i_sys_clk) disable iff (!rst_n)
      $rose(strap_taken_q) |-> (sleep_req_q == ~strap_q);
   endproperty
   a_strap_sleep: assert property (p_strap_sleep)
      else $error("sleep request not seeded from strap");

   property p_wake_only_by_write;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (i_clk_en && $past(strap_taken_q) && $fell(sleep_req_q[0])) |->
         $past(wr_w) && $past(reg_hit(i_paddr, OFF_SLEEP_CTRL));
   endproperty
   a_wake_only_by_write: assert property (p_wake_only_by_write)
      else $error("phy woke without register write");

   property p_set_sleep;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (i_clk_en && strap_taken_q && wr_w && reg_hit(i_paddr, OFF_SLEEP_CTRL) && i_pstrb[0]
         && i_pwdata[1]) |=> sleep_req_q[1];
   endproperty
   a_set_sleep: assert property (p_set_sleep)
      else $error("sleep request write lost");

   property p_port2_gated;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      o_link_up[1] |-> $past(!sleep_req_q[0], 2);
   endproperty
   a_port2_gated: assert property (p_port2_gated)
      else $error("port 2 linked with port 1 asleep");

   property p_hw_powerdown;
      @(posedge i_sys_clk)
      !i_nrst |=> (!o_pins_oe && o_phy_enable == '0 && !o_pready);
   endproperty
   a_hw_powerdown: assert property (p_hw_powerdown)
      else $error("outputs active during reset pin low");

   property p_bus_answers;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && acc_w && !o_pready) |=> o_pready;
   endproperty
   a_bus_answers: assert property (p_bus_answers)
      else $error("apb access not answered");

   property p_cut_through;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      !managed_q |=> !o_fwd_store_forward || !i_clk_en;
   endproperty
   a_cut_through: assert property (p_cut_through)
      else $error("unmanaged mode not cut-through");
endmodule // ppd_power_ctrl
`default_nettype wire
